//--- src/rs485_consts.svh
`ifndef RS485_CONSTS_SVH
`define RS485_CONSTS_SVH
`define RS485_FIFO_DEPTH 8
`define RS485_RX_WIDTH 10
`define RS485_PRESCALE_DIV4 4
`define RS485_SAMPLE_BASE 16
`define RS485_LCR_PARITY_LSB 3
`define RS485_LCR_FORCE0 3'b111
`define RS485_RX_PERR_BIT 8
`define RS485_RX_ADDR_BIT 9
`endif

//--- src/rs485_fifo.sv
`timescale 1ns/100ps
module rs485_fifo #(
  parameter int width = 10,
  parameter int depth = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Write side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  // Read side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0] wr_q;
  logic [aw-1:0] rd_q;
  logic [aw:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [aw:0] cnt_d = cnt_q + {{aw{1'b0}}, push} - {{aw{1'b0}}, pop};
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == aw'(depth - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == aw'(depth - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      // Ready comes from the next count, so it is a flop yet never lags a push.
      in_ready <= (cnt_d != depth[aw:0]);
    end
  end
endmodule

//--- src/rs485_pkg.sv
package rs485_pkg;
  typedef enum logic [1:0] {tx_idle, tx_start, tx_data, tx_stop} tx_state_t;
  typedef enum logic [1:0] {rx_idle, rx_start, rx_data, rx_stop} rx_state_t;
endpackage

//--- src/uart_rs485_multidrop_ctrl.sv
`timescale 1ns/100ps
`include "rs485_consts.svh"
// What this block does
// [RULE_01] Request-to-send follows modem bit or flow control unless auto-direction overrides.
// [RULE_02] Auto-direction drives request-to-send low on FIFO write, high after last bit.
// [RULE_03] Host turns hardware flow control off before auto-direction mode.
// [RULE_04] Inversion bit flips request-to-send polarity in auto-direction mode.
// [RULE_05] Multidrop bit selects 9-bit mode; ninth bit one marks an address.
// [RULE_06] Host-managed multidrop uses force parity zero, special detection off.
// [RULE_07] Receiver off: data dropped, address stored with parity error and interrupt.
// [RULE_08] Host enables receiver only when the address matches its identity.
// [RULE_09] Enabled receiver keeps data; next address again flags a parity error.
// [RULE_10] Auto mode drops data and non-matching addresses while receiver is off.
// [RULE_11] Matching address enables receiver, stored with ninth bit as parity error.
// [RULE_12] Auto mode enabled: mismatching address disables receiver and is dropped.
// [RULE_13] Baud generator supports non-16 sample rates, e.g. 24, 20.
// [RULE_14] Divisor 1 or 8 with sample rate 16 give the tabulated rates.
// [RULE_15] Baud equals clock over prescaler 1 or 4 over divisor times sample rate.
// [RULE_16] Sample rate is 16 minus sample count plus fractional compensation.
// [RULE_17] Direction releases only when FIFO and shifter are empty after stop bit.
module uart_rs485_multidrop_ctrl (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Configuration.
  input wire logic modem_ctrl_rts,
  input wire logic modem_ctrl_prescale4,
  input wire logic hw_flow_en,
  input wire logic hw_flow_rts,
  input wire logic auto_dir_en,
  input wire logic auto_dir_invert,
  input wire logic multidrop_en,
  input wire logic special_char_en,
  input wire logic [7:0] second_stop_char,
  input wire logic [5:0] line_format_ctrl,
  input wire logic line_irq_en,
  input wire logic [15:0] divisor,
  input wire logic [4:0] sample_count_reg,
  input wire logic [4:0] fractional_comp,
  // Host receiver enable control.
  input wire logic rx_enable_set,
  input wire logic rx_enable_clr,
  // Transmit data.
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [8:0] tx_data,
  // Receive data: bit 9 address, bit 8 parity error, bits 7..0 byte.
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [9:0] rx_data,
  // Status.
  output logic rx_enabled,
  output logic line_irq,
  // Line.
  input wire logic line_rx,
  output logic line_tx,
  output logic rts_n
);
  // Baud generator.
  logic [1:0] pre_q;
  logic [15:0] div_q;
  logic [5:0] smp_q;
  wire [5:0] sample_rate = 6'(`RS485_SAMPLE_BASE) - {1'b0, sample_count_reg} + {1'b0, fractional_comp}; // RULE_16
  wire pre_tick = !modem_ctrl_prescale4 || (pre_q == 2'(`RS485_PRESCALE_DIV4 - 1)); // RULE_15
  wire div_tick = pre_tick && (divisor != 16'h0000) && (div_q >= divisor - 16'h0001);
  wire bit_tick = div_tick && (smp_q >= sample_rate - 6'h01); // RULE_13 RULE_14
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pre_q <= 2'h0;
      div_q <= 16'h0000;
      smp_q <= 6'h00;
    end else begin
      pre_q <= pre_tick ? 2'h0 : pre_q + 2'h1;
      if (pre_tick) begin
        div_q <= div_tick ? 16'h0000 : div_q + 16'h0001;
      end
      if (div_tick) begin
        smp_q <= bit_tick ? 6'h00 : smp_q + 6'h01;
      end
    end
  end

  // Transmit path: always 8 data bits plus the ninth bit in multidrop mode.
  logic txf_valid;
  logic txf_ready;
  logic [8:0] txf_data;
  rs485_fifo #(.width(9), .depth(`RS485_FIFO_DEPTH)) u_tx_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(txf_valid),
    .out_ready(txf_ready),
    .out_data(txf_data)
  );
  rs485_pkg::tx_state_t tx_st_q;
  logic [8:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  wire [3:0] tx_bits = multidrop_en ? 4'h9 : 4'h8; // RULE_05
  assign txf_ready = (tx_st_q == rs485_pkg::tx_idle) && bit_tick;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tx_st_q <= rs485_pkg::tx_idle;
      tx_sh_q <= 9'h000;
      tx_cnt_q <= 4'h0;
      line_tx <= 1'b1;
    end else if (bit_tick) begin
      case (tx_st_q)
        rs485_pkg::tx_idle: begin
          line_tx <= !txf_valid;
          if (txf_valid) begin
            tx_sh_q <= txf_data;
            tx_st_q <= rs485_pkg::tx_start;
          end
        end
        rs485_pkg::tx_start: begin
          line_tx <= tx_sh_q[0];
          tx_sh_q <= {1'b0, tx_sh_q[8:1]};
          tx_cnt_q <= 4'h1;
          tx_st_q <= rs485_pkg::tx_data;
        end
        rs485_pkg::tx_data: begin
          if (tx_cnt_q == tx_bits) begin
            line_tx <= 1'b1;
            tx_st_q <= rs485_pkg::tx_stop;
          end else begin
            line_tx <= tx_sh_q[0];
            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
          end
        end
        rs485_pkg::tx_stop: begin
          // The stop bit is on the line in this state, so the driver stays on until it ends.
          line_tx <= 1'b1;
          tx_st_q <= rs485_pkg::tx_idle;
        end
        default: tx_st_q <= rs485_pkg::tx_idle;
      endcase
    end
  end

  // Direction control. Pending holds the direction for one cycle after tx_busy falls.
  logic tx_pend_q;
  wire tx_busy = tx_valid || txf_valid || (tx_st_q != rs485_pkg::tx_idle) || !line_tx; // RULE_17
  wire dir_level = (tx_busy || tx_pend_q) ? auto_dir_invert : !auto_dir_invert; // RULE_02 RULE_04
  wire flow_level = hw_flow_en ? hw_flow_rts : modem_ctrl_rts;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tx_pend_q <= 1'b0;
      rts_n <= 1'b1;
    end else begin
      tx_pend_q <= tx_busy;
      rts_n <= auto_dir_en ? dir_level : flow_level; // RULE_01
    end
  end

  // Receive line synchroniser: change counts when stages two and three agree.
  logic [2:0] rx_sync_q;
  logic rx_line_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rx_sync_q <= 3'b111;
      rx_line_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], line_rx};
      if (rx_sync_q[2] == rx_sync_q[1]) begin
        rx_line_q <= rx_sync_q[2];
      end
    end
  end

  // Receive deserialiser, sampling at the centre of each bit.
  rs485_pkg::rx_state_t rx_st_q;
  logic [5:0] rx_smp_q;
  logic [3:0] rx_cnt_q;
  logic [8:0] rx_sh_q;
  logic rx_done_q;
  wire rx_mid = div_tick && (rx_smp_q == {1'b0, sample_rate[5:1]});
  wire rx_end = div_tick && (rx_smp_q >= sample_rate - 6'h01);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rx_st_q <= rs485_pkg::rx_idle;
      rx_smp_q <= 6'h00;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (div_tick) begin
        rx_smp_q <= rx_end ? 6'h00 : rx_smp_q + 6'h01;
      end
      case (rx_st_q)
        rs485_pkg::rx_idle: begin
          rx_smp_q <= 6'h00;
          if (!rx_line_q) begin
            rx_st_q <= rs485_pkg::rx_start;
          end
        end
        rs485_pkg::rx_start: begin
          if (rx_mid) begin
            rx_st_q <= rx_line_q ? rs485_pkg::rx_idle : rs485_pkg::rx_data;
            rx_cnt_q <= 4'h0;
          end
        end
        rs485_pkg::rx_data: begin
          if (rx_mid) begin
            rx_sh_q <= multidrop_en ? {rx_line_q, rx_sh_q[8:1]} : {1'b0, rx_line_q, rx_sh_q[7:1]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == tx_bits - 4'h1) begin
              rx_st_q <= rs485_pkg::rx_stop;
            end
          end
        end
        rs485_pkg::rx_stop: begin
          if (rx_mid) begin
            rx_done_q <= 1'b1;
            rx_st_q <= rs485_pkg::rx_idle;
          end
        end
        default: rx_st_q <= rs485_pkg::rx_idle;
      endcase
    end
  end

  // Multidrop filter.
  wire is_addr = multidrop_en && rx_sh_q[8]; // RULE_05
  wire force0 = line_format_ctrl[`RS485_LCR_PARITY_LSB +: 3] == `RS485_LCR_FORCE0;
  wire auto_mode = multidrop_en && special_char_en;
  wire addr_match = (rx_sh_q[7:0] == second_stop_char);
  wire perr = is_addr && (auto_mode || force0); // RULE_07 RULE_09
  wire keep_manual = !multidrop_en || rx_enabled || is_addr; // RULE_07 RULE_09
  wire keep_auto = is_addr ? addr_match : rx_enabled; // RULE_10 RULE_12
  wire keep = auto_mode ? keep_auto : keep_manual;
  wire [9:0] rx_word = {is_addr, perr, rx_sh_q[7:0]}; // RULE_11 RULE_12
  wire rxf_in_ready;
  wire push = rx_done_q && keep;
  logic rxf_valid;
  logic [9:0] rxf_data;
  rs485_fifo #(.width(`RS485_RX_WIDTH), .depth(`RS485_FIFO_DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(push),
    .in_ready(rxf_in_ready),
    .in_data(rx_word),
    .out_valid(rxf_valid),
    .out_ready(rx_ready && !rx_valid),
    .out_data(rxf_data)
  );
  // A full FIFO drops the character, as an overrun would.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rx_enabled <= 1'b0;
      line_irq <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 10'h000;
    end else begin
      if (rx_done_q && auto_mode && is_addr) begin
        rx_enabled <= addr_match; // RULE_11 RULE_12
      end else if (rx_enable_set) begin
        rx_enabled <= 1'b1; // RULE_08
      end else if (rx_enable_clr) begin
        rx_enabled <= 1'b0;
      end
      line_irq <= push && rxf_in_ready && perr && line_irq_en; // RULE_07 RULE_11
      if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
      end else if (!rx_valid && rxf_valid && rx_ready) begin
        rx_valid <= 1'b1;
        rx_data <= rxf_data;
      end
    end
  end
endmodule

//--- test/rs485_station.sv
`timescale 1ns/100ps
module rs485_station #(
  parameter int bit_cycles = 4
) (
  // Clock.
  input wire logic sys_clk,
  // Line towards the block.
  output logic line_rx
);
  // The bus is biased to mark, so a released line reads high.
  initial line_rx = 1'h1;
  task automatic send_char(input logic [8:0] ch);
    line_rx <= 1'h0;
    repeat (bit_cycles) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      line_rx <= ch[i];
      repeat (bit_cycles) @(posedge sys_clk);
    end
    line_rx <= 1'h1;
    repeat (4 * bit_cycles) @(posedge sys_clk);
  endtask
endmodule

//--- test/uart_rs485_multidrop_ctrl_props.sv
`timescale 1ns/100ps
module uart_rs485_multidrop_ctrl_props (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Configuration.
  input wire logic modem_ctrl_rts,
  input wire logic hw_flow_en,
  input wire logic hw_flow_rts,
  input wire logic auto_dir_en,
  input wire logic auto_dir_invert,
  input wire logic multidrop_en,
  input wire logic special_char_en,
  input wire logic [5:0] line_format_ctrl,
  input wire logic rx_enable_set,
  input wire logic rx_enable_clr,
  // Data and status.
  input wire logic tx_valid,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [9:0] rx_data,
  input wire logic rx_enabled,
  input wire logic line_irq,
  input wire logic line_tx,
  input wire logic rts_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_rts_manual;
    !auto_dir_en |=> rts_n == ($past(hw_flow_en) ? $past(hw_flow_rts) : $past(modem_ctrl_rts));
  endproperty
  a_rts_manual: assert property (p_rts_manual) else $error("rts_n ignores manual source");
  property p_rts_tx; auto_dir_en && tx_valid |=> rts_n == $past(auto_dir_invert); endproperty
  a_rts_tx: assert property (p_rts_tx) else $error("rts_n not asserted on write");
  property p_rts_busy; auto_dir_en && !line_tx |=> rts_n == $past(auto_dir_invert); endproperty
  a_rts_busy: assert property (p_rts_busy) else $error("rts_n released mid frame");
  property p_irq_pulse; line_irq |=> !line_irq; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("line_irq longer than one cycle");
  property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx word lost while stalled");
  property p_off_addr; multidrop_en && !special_char_en && !rx_enabled && rx_valid |-> rx_data[9]; endproperty
  a_off_addr: assert property (p_off_addr) else $error("data kept with receiver off");
  property p_perr;
    multidrop_en && rx_valid && (special_char_en || line_format_ctrl[5:3] == 3'h7) |-> rx_data[8] == rx_data[9];
  endproperty
  a_perr: assert property (p_perr) else $error("parity error flag wrong");
  property p_set; rx_enable_set |=> rx_enabled; endproperty
  a_set: assert property (p_set) else $error("receiver not enabled");
  property p_clr; rx_enable_clr && !rx_enable_set |=> !rx_enabled; endproperty
  a_clr: assert property (p_clr) else $error("receiver not disabled");
endmodule
bind uart_rs485_multidrop_ctrl uart_rs485_multidrop_ctrl_props u_uart_rs485_multidrop_ctrl_props (.sys_clk, .reset_n,
  .modem_ctrl_rts, .hw_flow_en, .hw_flow_rts, .auto_dir_en, .auto_dir_invert, .multidrop_en, .special_char_en,
  .line_format_ctrl, .rx_enable_set, .rx_enable_clr, .tx_valid, .rx_valid, .rx_ready, .rx_data, .rx_enabled,
  .line_irq, .line_tx, .rts_n);

//--- test/uart_rs485_multidrop_ctrl_test.sv
`timescale 1ns/100ps
module uart_rs485_multidrop_ctrl_test;
  logic sys_clk, reset_n, modem_ctrl_rts, modem_ctrl_prescale4, hw_flow_en, hw_flow_rts, auto_dir_en;
  logic auto_dir_invert, multidrop_en, special_char_en, line_irq_en, rx_enable_set, rx_enable_clr, tx_valid;
  logic rx_ready, tx_ready, rx_valid, rx_enabled, line_irq, line_rx, line_tx, rts_n;
  logic [7:0] second_stop_char;
  logic [5:0] line_format_ctrl;
  logic [15:0] divisor;
  logic [4:0] sample_count_reg, fractional_comp;
  logic [8:0] tx_data;
  logic [9:0] rx_data;
  logic [9:0] rxq[$];
  int failures, samples_checked, cyc, irqs, w;
  uart_rs485_multidrop_ctrl u_uart_rs485_multidrop_ctrl (.sys_clk, .reset_n, .modem_ctrl_rts, .modem_ctrl_prescale4,
    .hw_flow_en, .hw_flow_rts, .auto_dir_en, .auto_dir_invert, .multidrop_en, .special_char_en, .second_stop_char,
    .line_format_ctrl, .line_irq_en, .divisor, .sample_count_reg, .fractional_comp, .rx_enable_set, .rx_enable_clr,
    .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data, .rx_enabled, .line_irq, .line_rx, .line_tx, .rts_n);
  rs485_station #(.bit_cycles(4)) u_rs485_station (.sys_clk, .line_rx);
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (rx_valid === 1'h1 && rx_ready === 1'h1) rxq.push_back(rx_data);
    if (line_irq === 1'h1) irqs++;
    if (cyc == 6000) begin
      failures++;
      print_verdict();
    end
  end
  task print_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [9:0] e, input logic [9:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task push(input logic [8:0] d);
    tx_data <= d;
    tx_valid <= 1'h1;
    tick(1);
    while (tx_ready !== 1'h1) tick(1);
    tx_valid <= 1'h0;
  endtask
  task pop(input logic [9:0] e);
    chk("rx word", e, rxq.size() > 0 ? rxq.pop_front() : 10'hxxx);
  endtask
  task hostrx(input logic s);
    rx_enable_set <= s;
    rx_enable_clr <= !s;
    tick(1);
    rx_enable_set <= 1'h0;
    rx_enable_clr <= 1'h0;
    tick(1);
    chk("rx_enabled", 10'(s), 10'(rx_enabled));
  endtask
  task t_rts_manual;
    for (int i = 0; i < 4; i++) begin
      hw_flow_en <= i[1];
      hw_flow_rts <= i[0];
      modem_ctrl_rts <= !i[0];
      tick(3);
      chk("rts manual", 10'(i[1] ? i[0] : !i[0]), 10'(rts_n));
    end
    $display("rts manual done");
  endtask
  task t_rts_auto(input logic inv);
    hw_flow_en <= 1'h0;
    auto_dir_en <= 1'h1;
    auto_dir_invert <= inv;
    tick(3);
    chk("rts idle", 10'(!inv), 10'(rts_n));
    push(9'h0ff);
    tick(1);
    chk("rts write", 10'(inv), 10'(rts_n));
    while (line_tx !== 1'h0) tick(1);
    tick(38);
    chk("rts stop bit", 10'(inv), 10'(rts_n));
    tick(12);
    chk("rts release", 10'(!inv), 10'(rts_n));
    $display("rts auto done");
  endtask
  task baud(input logic [15:0] d, input logic p, input logic [4:0] s, input logic [4:0] c, input int e);
    divisor <= d;
    modem_ctrl_prescale4 <= p;
    sample_count_reg <= s;
    fractional_comp <= c;
    tick(2);
    push(9'h0ff);
    w = 0;
    while (line_tx !== 1'h0) tick(1);
    while (line_tx === 1'h0) begin
      tick(1);
      w++;
    end
    chk("bit cycles", 10'(e), 10'(w));
    tick(10 * e);
  endtask
  task t_baud;
    baud(16'h3, 1'h0, 5'h10, 5'h2, 6);
    baud(16'h2, 1'h1, 5'he, 5'h0, 16);
    baud(16'h1, 1'h0, 5'h0, 5'h0, 16);
    baud(16'h1, 1'h0, 5'h0, 5'h8, 24);
    baud(16'h1, 1'h0, 5'hc, 5'h0, 4);
    $display("baud done");
  endtask
  task t_fill;
    // A zero divisor halts the bit clock, so nothing drains while filling.
    divisor <= 16'h0;
    tick(2);
    tx_valid <= 1'h1;
    w = 0;
    repeat (12) begin
      tick(1);
      if (tx_ready === 1'h1) w++;
    end
    tx_valid <= 1'h0;
    chk("tx fill", 10'h8, 10'(w));
    chk("rts pending", 10'h0, 10'(rts_n));
    divisor <= 16'h1;
    tick(360);
    chk("rts drained", 10'h1, 10'(rts_n));
    $display("fill done");
  endtask
  task t_manual;
    multidrop_en <= 1'h1;
    line_format_ctrl <= 6'h38;
    rx_ready <= 1'h0;
    hostrx(1'h0);
    irqs = 0;
    u_rs485_station.send_char(9'h055);
    u_rs485_station.send_char(9'h1a5);
    chk("stalled", 10'h0, 10'(rxq.size()));
    rx_ready <= 1'h1;
    tick(6);
    pop(10'h3a5);
    chk("irq count", 10'h1, 10'(irqs));
    hostrx(1'h1);
    u_rs485_station.send_char(9'h033);
    pop(10'h033);
    line_irq_en <= 1'h0;
    irqs = 0;
    u_rs485_station.send_char(9'h1b0);
    pop(10'h3b0);
    chk("irq masked", 10'h0, 10'(irqs));
    line_irq_en <= 1'h1;
    hostrx(1'h0);
    u_rs485_station.send_char(9'h044);
    chk("dropped", 10'h0, 10'(rxq.size()));
    $display("manual multidrop done");
  endtask
  task t_auto;
    special_char_en <= 1'h1;
    second_stop_char <= 8'h5a;
    irqs = 0;
    u_rs485_station.send_char(9'h011);
    u_rs485_station.send_char(9'h133);
    chk("dropped", 10'h0, 10'(rxq.size()));
    u_rs485_station.send_char(9'h15a);
    pop(10'h35a);
    chk("auto enable", 10'h1, 10'(rx_enabled));
    u_rs485_station.send_char(9'h022);
    pop(10'h022);
    u_rs485_station.send_char(9'h177);
    u_rs485_station.send_char(9'h000);
    chk("dropped", 10'h0, 10'(rxq.size()));
    chk("auto disable", 10'h0, 10'(rx_enabled));
    chk("irq count", 10'h1, 10'(irqs));
    multidrop_en <= 1'h0;
    special_char_en <= 1'h0;
    u_rs485_station.send_char(9'h1c3);
    pop(10'h0c3);
    $display("auto address done");
  endtask
  initial begin
    {sys_clk, reset_n, modem_ctrl_rts, modem_ctrl_prescale4, hw_flow_en, hw_flow_rts, auto_dir_en, auto_dir_invert,
      multidrop_en, special_char_en, rx_enable_set, rx_enable_clr, tx_valid, tx_data, second_stop_char,
      line_format_ctrl, fractional_comp} = '0;
    divisor = 16'h1;
    sample_count_reg = 5'hc;
    line_irq_en = 1'h1;
    rx_ready = 1'h1;
    tick(10);
    reset_n <= 1'h1;
    tick(2);
    t_rts_manual();
    t_rts_auto(1'h1);
    t_rts_auto(1'h0);
    t_baud();
    t_fill();
    t_manual();
    t_auto();
    print_verdict();
  end
endmodule
